// *** src/rmp_defs.vh ***
// constants for the reading math post-processor
// assumes: included by the design file and the bench; 10 MHz system clock
`ifndef RMP_DEFS_VH
`define RMP_DEFS_VH

// register byte offsets
`define RMP_OFS_OP_SEL   8'h00
`define RMP_OFS_CFG      8'h04
`define RMP_OFS_OFFSET   8'h08
`define RMP_OFS_REL_REF  8'h0C
`define RMP_OFS_HI_LIM   8'h10
`define RMP_OFS_LO_LIM   8'h14
`define RMP_OFS_STATUS   8'h18
`define RMP_OFS_MAX      8'h1C
`define RMP_OFS_MIN      8'h20
`define RMP_OFS_MEAN     8'h24
`define RMP_OFS_COUNT    8'h28
`define RMP_OFS_PRIMARY  8'h2C

// config field positions
`define RMP_CFG_BEEP_BIT 0
`define RMP_CFG_RREF_LSB 4
`define RMP_CFG_RREF_MSB 8

// math operation codes
`define RMP_OP_NONE      3'h0
`define RMP_OP_OFFSET    3'h1
`define RMP_OP_POWER     3'h2
`define RMP_OP_RELATIVE  3'h3
`define RMP_OP_STATS     3'h4
`define RMP_OP_LIMIT     3'h5
`define RMP_OP_HOLD      3'h6

// measurement function codes
`define RMP_FN_DCV       4'h0
`define RMP_FN_ACV       4'h1
`define RMP_FN_CONT      4'h8
`define RMP_FN_DIODE     4'h9

// limit classes
`define RMP_CLS_PASS     2'h0
`define RMP_CLS_HI       2'h1
`define RMP_CLS_LO       2'h2

// reset values
`define RMP_RST_WORD     32'h0000_0000
`define RMP_RST_RREF     5'h0F

// levels in hundredths of a dB; readings are 1 uV per lsb
`define RMP_DB_LIMIT     32'h0000_2EE0
`define RMP_DB_UV_OFFSET 32'hFFFF_DCD8
`define RMP_LOG_SCALE    40'h00_0000_25A1

// statistics count display limit
`define RMP_COUNT_INT_MAX 32'h0001_D4C0

// timing: indicator pulse length
`define RMP_CLK_KHZ      21'h0_2710
`define RMP_IND_TIME_MS  21'h0_0064

`endif

// *** src/rmp_math_unit.v ***
// reading math post-processor: one math operation on a reading stream
// assumes: converter, function code and full scale on hclk; AHB-Lite
`timescale 1ns/100ps
`include "rmp_defs.vh"

module rmp_math_unit #(
  parameter [20:0] IND_CYCLES = `RMP_IND_TIME_MS * `RMP_CLK_KHZ
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // readings from the converter
  input  wire        rd_valid,
  input  wire [31:0] rd_value,
  input  wire [3:0]  meas_function,
  input  wire [31:0] range_full_scale,
  input  wire [31:0] func_max_range,
  // results to display and beeper
  output reg         res_valid,
  output reg  [31:0] res_primary,
  output reg  [31:0] res_secondary,
  output reg  [2:0]  active_op,
  output reg  [1:0]  limit_class,
  output reg         ind_max,
  output reg         ind_min,
  output reg         beep
);

  // clamp a signed value to the range -lim to lim
  function signed [31:0] rm_clamp;
    input signed [31:0] v;
    input signed [31:0] lim;
    begin
      if (v > lim)
        rm_clamp = lim;
      else if (v < -lim)
        rm_clamp = -lim;
      else
        rm_clamp = v;
    end
  endfunction

  // log2 in q.16, quadratic fraction correction
  function [21:0] rm_log2;
    input [31:0] v;
    integer i;
    reg [4:0]  e;
    reg [31:0] m;
    reg [15:0] x;
    reg [31:0] c;
    reg [25:0] k;
    begin
      e = 5'h00;
      for (i = 0; i < 32; i = i + 1)
        if (v[i])
          e = i[4:0];
      m = v << (5'd31 - e);
      x = m[30:15];
      c = {16'h0000, x} * (32'h0001_0000 - {16'h0000, x});
      k = {10'h000, c[31:16]} * 26'd355;
      rm_log2 = {1'b0, e, 16'h0000} + {6'h00, x} + {6'h00, k[25:10]};
    end
  endfunction

  // hundred times ten log10 of each reference resistance
  function signed [31:0] rm_rref_db;
    input [4:0] sel;
    begin
      case (sel)
        5'd0:    rm_rref_db = 32'sd301;
        5'd1:    rm_rref_db = 32'sd602;
        5'd2:    rm_rref_db = 32'sd903;
        5'd3:    rm_rref_db = 32'sd1204;
        5'd4:    rm_rref_db = 32'sd1699;
        5'd5:    rm_rref_db = 32'sd1875;
        5'd6:    rm_rref_db = 32'sd1968;
        5'd7:    rm_rref_db = 32'sd2041;
        5'd8:    rm_rref_db = 32'sd2093;
        5'd9:    rm_rref_db = 32'sd2097;
        5'd10:   rm_rref_db = 32'sd2130;
        5'd11:   rm_rref_db = 32'sd2176;
        5'd12:   rm_rref_db = 32'sd2398;
        5'd13:   rm_rref_db = 32'sd2477;
        5'd14:   rm_rref_db = 32'sd2699;
        5'd15:   rm_rref_db = 32'sd2778;
        5'd16:   rm_rref_db = 32'sd2903;
        5'd17:   rm_rref_db = 32'sd2954;
        5'd18:   rm_rref_db = 32'sd3000;
        5'd19:   rm_rref_db = 32'sd3079;
        default: rm_rref_db = 32'sd3903;
      endcase
    end
  endfunction

  function [31:0] rm_abs;
    input [31:0] v;
    begin
      rm_abs = v[31] ? (32'h0000_0000 - v) : v;
    end
  endfunction

  // control and data registers
  reg        beep_en;
  reg [4:0]  rref_sel;
  reg [31:0] offset_val;
  reg [31:0] rel_ref;
  reg [31:0] hi_limit;
  reg [31:0] lo_limit;
  reg [31:0] st_max;
  reg [31:0] st_min;
  reg [47:0] st_sum;
  reg [31:0] st_count;
  reg [31:0] st_mean;
  reg        capture_pend;
  reg [3:0]  prev_function;
  reg [31:0] held;
  reg [31:0] win [0:2];
  reg [2:0]  win_fill;
  reg [20:0] max_cnt;
  reg [20:0] min_cnt;
  // mean divider
  reg        div_busy;
  reg [5:0]  div_step;
  reg [47:0] div_q;
  reg [32:0] div_rem;
  reg [31:0] div_den;
  reg        div_neg;
  // ahb data phase
  reg        dp_write;
  reg [7:0]  dp_addr;

  wire signed [31:0] rd_s = rd_value;
  wire [31:0] rd_mag = rm_abs(rd_value);

  // power level of the present reading
  wire [21:0] log_l = rm_log2(rd_mag);
  wire [39:0] log_p = {18'h0_0000, log_l} * `RMP_LOG_SCALE;
  wire signed [31:0] pw_raw = $signed({12'h000, log_p[39:20]})
                              - rm_rref_db(rref_sel)
                              + $signed(`RMP_DB_UV_OFFSET);
  wire signed [31:0] pw_level = (rd_mag == 32'h0000_0000) ?
    -$signed(`RMP_DB_LIMIT) :
    rm_clamp(pw_raw, `RMP_DB_LIMIT);
  wire signed [31:0] rel_level = rm_clamp(pw_level - $signed(rel_ref),
                                          `RMP_DB_LIMIT);

  // operations permitted for the present function
  wire fn_voltage = (meas_function == `RMP_FN_DCV) ||
                    (meas_function == `RMP_FN_ACV);
  wire fn_no_math = (meas_function == `RMP_FN_CONT) ||
                    (meas_function == `RMP_FN_DIODE);

  // ahb decode: one wait-free cycle, always okay
  wire ahb_go   = hsel && hready && htrans[1];
  wire sw_wr    = dp_write;
  wire [31:0] lim120 = func_max_range + func_max_range / 32'd5;
  wire [31:0] wr_lim = rm_clamp(hwdata, lim120);
  wire [2:0]  sel_op = hwdata[2:0];
  wire sel_wr   = sw_wr && (dp_addr == `RMP_OFS_OP_SEL);
  wire sel_ok   = !fn_no_math &&
                  (((sel_op == `RMP_OP_POWER) ||
                    (sel_op == `RMP_OP_RELATIVE)) ? fn_voltage :
                   (sel_op != `RMP_OP_NONE) && (sel_op <= `RMP_OP_HOLD));
  wire op_off   = sel_wr && ((sel_op == active_op) ||
                             (sel_op == `RMP_OP_NONE));
  wire op_on    = sel_wr && !op_off && sel_ok;
  wire fn_chg   = meas_function != prev_function;
  wire rd_go    = rd_valid && !op_on && !op_off && !fn_chg;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // statistics next values
  wire first_st   = (st_count == 32'h0000_0000);
  wire new_max    = first_st || (rd_s > $signed(st_max));
  wire new_min    = first_st || (rd_s < $signed(st_min));
  wire [47:0] next_sum   = st_sum + {{16{rd_value[31]}}, rd_value};
  wire [31:0] next_count = st_count + 32'h0000_0001;

  // hold window over the new reading and three before it
  reg signed [31:0] w_max;
  reg signed [31:0] w_min;
  integer j;
  always @* begin
    w_max = rd_s;
    w_min = rd_s;
    for (j = 0; j < 3; j = j + 1) begin
      if ($signed(win[j]) > w_max)
        w_max = win[j];
      if ($signed(win[j]) < w_min)
        w_min = win[j];
    end
  end
  wire [31:0] w_spread = w_max - w_min;
  wire [31:0] held_dif = rm_abs(rd_value - held);
  wire hold_upd = (win_fill == 3'd3) &&
                  (w_spread <= rd_mag / 32'd1000) &&
                  (rd_mag >= range_full_scale / 32'd20) &&
                  (held_dif >= range_full_scale / 32'd1000);

  // limit classification of the present reading
  wire [1:0] next_class = (rd_s > $signed(hi_limit)) ? `RMP_CLS_HI :
                          (rd_s < $signed(lo_limit)) ? `RMP_CLS_LO :
                          `RMP_CLS_PASS;

  // operation selection, function watch and per-reading math
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_op     <= `RMP_OP_NONE;
      prev_function <= 4'h0;
      capture_pend  <= 1'b0;
      offset_val    <= `RMP_RST_WORD;
      rel_ref       <= `RMP_RST_WORD;
      hi_limit      <= `RMP_RST_WORD;
      lo_limit      <= `RMP_RST_WORD;
      beep_en       <= 1'b0;
      rref_sel      <= `RMP_RST_RREF;
      st_max        <= `RMP_RST_WORD;
      st_min        <= `RMP_RST_WORD;
      st_sum        <= 48'h0000_0000_0000;
      st_count      <= `RMP_RST_WORD;
      held          <= `RMP_RST_WORD;
      win[0]        <= `RMP_RST_WORD;
      win[1]        <= `RMP_RST_WORD;
      win[2]        <= `RMP_RST_WORD;
      win_fill      <= 3'd0;
      limit_class   <= `RMP_CLS_PASS;
      res_valid     <= 1'b0;
      res_primary   <= `RMP_RST_WORD;
      res_secondary <= `RMP_RST_WORD;
      beep          <= 1'b0;
    end else begin
      res_valid     <= 1'b0;
      beep          <= 1'b0;
      prev_function <= meas_function;
      // software writes; hardware captures below take precedence
      if (sw_wr && dp_addr == `RMP_OFS_CFG) begin
        beep_en  <= hwdata[`RMP_CFG_BEEP_BIT];
        rref_sel <= (hwdata[`RMP_CFG_RREF_MSB:`RMP_CFG_RREF_LSB] > 5'd20) ?
                    5'd20 : hwdata[`RMP_CFG_RREF_MSB:`RMP_CFG_RREF_LSB];
      end
      if (sw_wr && dp_addr == `RMP_OFS_OFFSET)
        offset_val <= hwdata;
      if (sw_wr && dp_addr == `RMP_OFS_REL_REF)
        rel_ref <= rm_clamp(hwdata, `RMP_DB_LIMIT);
      if (sw_wr && dp_addr == `RMP_OFS_HI_LIM)
        hi_limit <= wr_lim;
      if (sw_wr && dp_addr == `RMP_OFS_LO_LIM)
        lo_limit <= wr_lim;
      if (fn_chg) begin
        active_op    <= `RMP_OP_NONE;
        capture_pend <= 1'b0;
      end else if (op_off) begin
        active_op    <= `RMP_OP_NONE;
        capture_pend <= 1'b0;
      end else if (op_on) begin
        active_op    <= sel_op;
        capture_pend <= 1'b1;
        st_count     <= `RMP_RST_WORD;
        st_sum       <= 48'h0000_0000_0000;
        st_max       <= `RMP_RST_WORD;
        st_min       <= `RMP_RST_WORD;
        win_fill     <= 3'd0;
        limit_class  <= `RMP_CLS_PASS;
      end else if (rd_go) begin
        // range changes need no handling here
        res_valid     <= 1'b1;
        res_primary   <= rd_value;
        res_secondary <= rd_value;
        capture_pend  <= 1'b0;
        case (active_op)
          `RMP_OP_OFFSET: begin
            if (capture_pend) begin
              offset_val  <= rd_value;
              res_primary <= `RMP_RST_WORD;
            end else begin
              res_primary <= rd_value - offset_val;
            end
            res_secondary <= capture_pend ? rd_value : offset_val;
          end
          `RMP_OP_POWER: begin
            res_primary <= pw_level;
          end
          `RMP_OP_RELATIVE: begin
            if (capture_pend) begin
              rel_ref     <= pw_level;
              res_primary <= `RMP_RST_WORD;
            end else begin
              res_primary <= rel_level;
            end
          end
          `RMP_OP_STATS: begin
            st_count <= next_count;
            st_sum   <= next_sum;
            if (new_max)
              st_max <= rd_value;
            if (new_min)
              st_min <= rd_value;
            if ((new_max || new_min) && beep_en)
              beep <= 1'b1;
            res_secondary <= new_max ? rd_value : st_max;
          end
          `RMP_OP_LIMIT: begin
            limit_class <= next_class;
            if (beep_en && next_class != limit_class &&
                next_class != `RMP_CLS_PASS)
              beep <= 1'b1;
          end
          `RMP_OP_HOLD: begin
            win[0] <= rd_value;
            win[1] <= win[0];
            win[2] <= win[1];
            if (win_fill != 3'd3)
              win_fill <= win_fill + 3'd1;
            if (hold_upd) begin
              held        <= rd_value;
              res_primary <= rd_value;
              beep        <= beep_en;
            end else begin
              res_primary <= held;
            end
          end
          default: begin
            res_primary <= rd_value;
          end
        endcase
      end
    end
  end

  // max and min indicator stretchers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      max_cnt <= 21'd0;
      min_cnt <= 21'd0;
      ind_max <= 1'b0;
      ind_min <= 1'b0;
    end else begin
      ind_max <= (max_cnt != 21'd0);
      ind_min <= (min_cnt != 21'd0);
      if (rd_go && active_op == `RMP_OP_STATS && new_max)
        max_cnt <= IND_CYCLES;
      else if (max_cnt != 21'd0)
        max_cnt <= max_cnt - 21'd1;
      if (rd_go && active_op == `RMP_OP_STATS && new_min)
        min_cnt <= IND_CYCLES;
      else if (min_cnt != 21'd0)
        min_cnt <= min_cnt - 21'd1;
    end
  end

  // serial divider: mean is sum over count, restarts per reading
  wire [32:0] div_try = {div_rem[31:0], div_q[47]};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_busy <= 1'b0;
      div_step <= 6'd0;
      div_q    <= 48'h0000_0000_0000;
      div_rem  <= 33'h0_0000_0000;
      div_den  <= `RMP_RST_WORD;
      div_neg  <= 1'b0;
      st_mean  <= `RMP_RST_WORD;
    end else if (op_on) begin
      div_busy <= 1'b0;
      st_mean  <= `RMP_RST_WORD;
    end else if (rd_go && active_op == `RMP_OP_STATS) begin
      div_busy <= 1'b1;
      div_step <= 6'd0;
      div_neg  <= next_sum[47];
      div_q    <= next_sum[47] ? (48'h0000_0000_0000 - next_sum) : next_sum;
      div_rem  <= 33'h0_0000_0000;
      div_den  <= next_count;
    end else if (div_busy) begin
      if (div_try >= {1'b0, div_den}) begin
        div_rem <= div_try - {1'b0, div_den};
        div_q   <= {div_q[46:0], 1'b1};
      end else begin
        div_rem <= div_try;
        div_q   <= {div_q[46:0], 1'b0};
      end
      div_step <= div_step + 6'd1;
      if (div_step == 6'd47) begin
        div_busy <= 1'b0;
        st_mean  <= div_neg ? (32'h0000_0000 - {div_q[30:0], 1'b0}) -
                              {31'h0000_0000, div_try >= {1'b0, div_den}}
                            : {div_q[30:0], div_try >= {1'b0, div_den}};
      end
    end
  end

  // ahb address phase capture and registered read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= `RMP_RST_WORD;
    end else begin
      dp_write <= ahb_go && hwrite;
      dp_addr  <= haddr;
      if (ahb_go && !hwrite) begin
        case (haddr)
          `RMP_OFS_OP_SEL:  hrdata <= {29'h0000_0000, active_op};
          `RMP_OFS_CFG:     hrdata <= {23'h00_0000, rref_sel, 3'h0, beep_en};
          `RMP_OFS_OFFSET:  hrdata <= offset_val;
          `RMP_OFS_REL_REF: hrdata <= rel_ref;
          `RMP_OFS_HI_LIM:  hrdata <= hi_limit;
          `RMP_OFS_LO_LIM:  hrdata <= lo_limit;
          `RMP_OFS_STATUS:  hrdata <= {26'h000_0000, div_busy,
                                       st_count > `RMP_COUNT_INT_MAX,
                                       capture_pend, 1'b0,
                                       limit_class};
          `RMP_OFS_MAX:     hrdata <= st_max;
          `RMP_OFS_MIN:     hrdata <= st_min;
          `RMP_OFS_MEAN:    hrdata <= st_mean;
          `RMP_OFS_COUNT:   hrdata <= st_count;
          `RMP_OFS_PRIMARY: hrdata <= res_primary;
          default:          hrdata <= `RMP_RST_WORD;
        endcase
      end
    end
  end

endmodule // rmp_math_unit

// *** tb/rmp_math_props.sv ***
// checker for the reading math post-processor, bound to its top ports
// assumes: one clock domain, reset active low, indicator length parameter
`timescale 1ns/100ps

module rmp_math_props #(
  parameter [20:0] IND_CYCLES = 21'h4
) (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus answer
  input wire        hreadyout,
  input wire        hresp,
  // reading stream
  input wire        rd_valid,
  input wire [31:0] rd_value,
  input wire [3:0]  meas_function,
  // results
  input wire        res_valid,
  input wire [31:0] res_primary,
  input wire [31:0] res_secondary,
  input wire [2:0]  active_op,
  input wire [1:0]  limit_class,
  input wire        ind_max,
  input wire        beep
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // length of the present high run of the max indicator
  reg [20:0] ind_run;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ind_run <= 21'h0;
    else if (ind_max)
      ind_run <= ind_run + 21'h1;
    else
      ind_run <= 21'h0;
  end

  // steps: function moves; a result under power or relative
  sequence fn_move_s;
    meas_function != $past(meas_function);
  endsequence
  sequence lvl_res_s;
    res_valid && (active_op == 3'h2 || active_op == 3'h3);
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  fn_off_a: assert property (fn_move_s |=> active_op == 3'h0)
    else $error("operation survived a function change");
  lvl_fn_a: assert property ($stable(meas_function) &&
    (active_op == 3'h2 || active_op == 3'h3) |-> meas_function < 4'h2)
    else $error("level operation on a non-voltage function");
  no_math_a: assert property ($stable(meas_function) &&
    meas_function >= 4'h8 |-> active_op == 3'h0)
    else $error("operation active on continuity or diode");
  lvl_clamp_a: assert property (lvl_res_s |->
    $signed(res_primary) <= 12000 && $signed(res_primary) >= -12000)
    else $error("level result outside clamp");
  stats_max_a: assert property (res_valid && active_op == 3'h4
    |-> $signed(res_secondary) >= $signed(res_primary))
    else $error("running max below reading");
  ind_cause_a: assert property ($rose(ind_max) |-> $past(res_valid))
    else $error("max indicator without a result");
  ind_len_a: assert property ($fell(ind_max) |->
    ind_run >= IND_CYCLES)
    else $error("max indicator pulse too short");
  class_code_a: assert property (limit_class != 2'h3)
    else $error("limit class out of range");
  pass_quiet_a: assert property (res_valid && active_op == 3'h5 &&
    limit_class == 2'h0 |-> !beep)
    else $error("beep on a pass result");
  beep_res_a: assert property (beep |-> res_valid)
    else $error("beep without a result");
  hold_live_a: assert property (res_valid && active_op == 3'h6
    |-> res_secondary == $past(rd_value))
    else $error("live reading not passed on in hold");
  res_cause_a: assert property (res_valid |-> $past(rd_valid))
    else $error("result without a reading");
endmodule // rmp_math_props

// *** tb/rmp_conv_model.sv ***
// converter model: hands readings to the post-processor
// assumes: bench calls send; lines change just after a rising edge
`timescale 1ns/100ps

module rmp_conv_model (
  // clock
  input wire        hclk,
  // reading stream
  output reg        rd_valid,
  output reg [31:0] rd_value
);
  // idle lines at time zero
  initial begin
    rd_valid = 1'b0;
    rd_value = 32'h0000_0000;
  end

  // one reading after gap cycles; stale value is inverted afterwards
  task send(input [31:0] v, input [3:0] gap);
    begin
      repeat (gap) @(posedge hclk);
      @(posedge hclk);
      rd_valid <= 1'b1;
      rd_value <= v;
      @(posedge hclk);
      rd_valid <= 1'b0;
      rd_value <= ~v;
    end
  endtask
endmodule // rmp_conv_model

// *** tb/rmp_math_unit_bench.sv ***
// bench for the reading math post-processor
// assumes: design with short indicator, converter model beside it
`timescale 1ns/100ps
`include "rmp_defs.vh"

module rmp_math_unit_bench;
  // stimulus and observed wires
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0000_0000;
  reg  [3:0]  meas_function = 4'h0;
  reg  [31:0] range_full_scale = 32'h000F_4240;
  reg  [31:0] func_max_range = 32'h000F_4240;
  reg  [31:0] rv;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  wire        hreadyout, hresp, rd_valid, res_valid, ind_max, ind_min, beep;
  wire [31:0] hrdata, rd_value, res_primary, res_secondary;
  wire [2:0]  active_op;
  wire [1:0]  limit_class;

  // clock
  always #50 hclk = ~hclk;

  rmp_math_unit #(.IND_CYCLES(21'h4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rd_valid(rd_valid), .rd_value(rd_value),
    .meas_function(meas_function), .range_full_scale(range_full_scale),
    .func_max_range(func_max_range), .res_valid(res_valid),
    .res_primary(res_primary), .res_secondary(res_secondary),
    .active_op(active_op), .limit_class(limit_class), .ind_max(ind_max),
    .ind_min(ind_min), .beep(beep));

  rmp_conv_model conv_u (.hclk(hclk), .rd_valid(rd_valid),
    .rd_value(rd_value));

  // comparison and verdict
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // one single ahb-lite word transfer
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rv, e);
    end
  endtask
  task op(input [2:0] c);
    wr(`RMP_OFS_OP_SEL, {29'h0, c});
  endtask
  task fn(input [3:0] f);
    begin
      @(posedge hclk);
      meas_function <= f;
    end
  endtask
  // one reading; result is looked at after its edge
  task rdg(input [31:0] v);
    begin
      conv_u.send(v, 4'h0);
      @(negedge hclk);
      chk({31'h0, res_valid}, 32'h0000_0001);
    end
  endtask

  // reset values, saturating resistor index, unmapped place
  task t_reset;
    begin
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      rdc(`RMP_OFS_CFG, 32'h0000_00F0);
      rdc(`RMP_OFS_REL_REF, 32'h0000_0000);
      rdc(`RMP_OFS_HI_LIM, 32'h0000_0000);
      rdc(`RMP_OFS_LO_LIM, 32'h0000_0000);
      rdc(8'h3C, 32'h0000_0000);
      wr(`RMP_OFS_CFG, 32'h0000_0191);
      rdc(`RMP_OFS_CFG, 32'h0000_0141);
      wr(`RMP_OFS_CFG, 32'h0000_00F1);
      $display("reset test done");
    end
  endtask

  // every code on, off again, and switching
  task t_ops;
    integer i;
    begin
      for (i = 1; i < 7; i = i + 1) begin
        op(i[2:0]);
        rdc(`RMP_OFS_OP_SEL, i);
        op(i[2:0]);
        rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      end
      op(3'h1);
      op(3'h5);
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0005);
      $display("select test done");
    end
  endtask

  // function changes, allowed sets, range change
  task t_func;
    integer i;
    begin
      fn(4'h2);
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      op(3'h2);
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      op(3'h4);
      @(posedge hclk);
      range_full_scale <= 32'h0001_86A0;
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0004);
      fn(4'h8);
      for (i = 1; i < 7; i = i + 1) begin
        op(i[2:0]);
        rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      end
      fn(4'h1);
      op(3'h3);
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0003);
      fn(4'h0);
      range_full_scale <= 32'h000F_4240;
      rdc(`RMP_OFS_OP_SEL, 32'h0000_0000);
      $display("function test done");
    end
  endtask

  // offset capture then subtraction
  task t_offset;
    begin
      op(3'h1);
      rdg(32'h0000_03E8);
      chk(res_primary, 32'h0000_0000);
      rdg(32'h0000_05DC);
      chk(res_primary, 32'h0000_01F4);
      rdc(`RMP_OFS_OFFSET, 32'h0000_03E8);
      $display("offset test done");
    end
  endtask

  // statistics, min indicator, clearing on enable
  task t_stats;
    begin
      op(3'h4);
      rdg(32'h0000_0005);
      rdg(32'h0000_0009);
      chk(res_secondary, 32'h0000_0009);
      @(negedge hclk);
      rdg(32'h0000_0002);
      chk({31'h0, beep}, 32'h0000_0001);
      @(negedge hclk);
      chk({31'h0, ind_min}, 32'h0000_0001);
      repeat (60) @(posedge hclk);
      rdc(`RMP_OFS_COUNT, 32'h0000_0003);
      rdc(`RMP_OFS_MAX, 32'h0000_0009);
      rdc(`RMP_OFS_MIN, 32'h0000_0002);
      rdc(`RMP_OFS_MEAN, 32'h0000_0005);
      rdc(`RMP_OFS_STATUS, 32'h0000_0000);
      op(3'h4);
      op(3'h4);
      rdc(`RMP_OFS_COUNT, 32'h0000_0000);
      $display("statistics test done");
    end
  endtask

  // one limit reading with its class and beep
  task lim(input [31:0] v, input [1:0] c, input b);
    begin
      rdg(v);
      chk({30'h0, limit_class}, {30'h0, c});
      chk({31'h0, beep}, {31'h0, b});
    end
  endtask
  task t_limit;
    begin
      wr(`RMP_OFS_HI_LIM, 32'h0000_0064);
      wr(`RMP_OFS_LO_LIM, 32'hFFFF_FF9C);
      op(3'h5);
      lim(32'h0000_0032, 2'h0, 1'b0);
      lim(32'h0000_00C8, 2'h1, 1'b1);
      lim(32'hFFFF_FF38, 2'h2, 1'b1);
      lim(32'h0000_0000, 2'h0, 1'b0);
      wr(`RMP_OFS_HI_LIM, 32'h00FF_FFFF);
      rdc(`RMP_OFS_HI_LIM, 32'h0012_4F80);
      $display("limit test done");
    end
  endtask

  // power floor, relative capture and clamp
  task t_level;
    begin
      op(3'h2);
      rdg(32'h0000_0000);
      chk(res_primary, 32'hFFFF_D120);
      rdg(32'h000F_4240);
      rv = {31'h0, res_primary > 32'h0000_00D8 && res_primary < 32'h0000_00E4};
      chk(rv, 32'h0000_0001);
      op(3'h3);
      rdg(32'h0000_0000);
      chk(res_primary, 32'h0000_0000);
      rdg(32'h7FFF_FFFF);
      chk(res_primary, 32'h0000_2EE0);
      rdc(`RMP_OFS_REL_REF, 32'hFFFF_D120);
      $display("level test done");
    end
  endtask

  // hold on a steady reading, none below the level floor
  task t_hold;
    integer i;
    begin
      op(3'h6);
      for (i = 0; i < 3; i = i + 1)
        rdg(32'h0007_A120);
      chk(res_primary, 32'h0000_0000);
      rdg(32'h0007_A120);
      chk(res_primary, 32'h0007_A120);
      chk({31'h0, beep}, 32'h0000_0001);
      for (i = 0; i < 4; i = i + 1)
        rdg(32'h0000_03E8);
      chk(res_primary, 32'h0007_A120);
      chk(res_secondary, 32'h0000_03E8);
      $display("hold test done");
    end
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_ops;
    t_func;
    t_offset;
    t_stats;
    t_limit;
    t_level;
    t_hold;
    report_and_stop;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
endmodule // rmp_math_unit_bench

bind rmp_math_unit rmp_math_props #(.IND_CYCLES(IND_CYCLES)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .rd_valid(rd_valid), .rd_value(rd_value), .meas_function(meas_function),
  .res_valid(res_valid), .res_primary(res_primary),
  .res_secondary(res_secondary), .active_op(active_op),
  .limit_class(limit_class), .ind_max(ind_max), .beep(beep));
